// >>> epsc_pkg.sv
// Shared constants and types for the paging and stack check block
package epsc_pkg;

  // Address layout
  localparam int unsigned EA_W         = 16;
  localparam int unsigned XA_W         = 24;
  localparam int unsigned EXT_BIT      = 15;
  localparam int unsigned RPAG_W       = 10;
  localparam int unsigned WPAG_W       = 9;
  localparam int unsigned PVIEW_BIT    = 9;
  localparam logic [15:0] SFR_TOP      = 16'h0800;
  localparam logic [15:0] SP_RESET     = 16'h0800;
  localparam logic [15:0] SP_STEP      = 16'h0002;
  localparam logic [9:0]  RPAG_RESET   = 10'h001;
  localparam logic [8:0]  WPAG_RESET   = 9'h001;

  // Core command codes
  typedef enum logic [3:0] {
    EPSC_OP_READ      = 4'h0,
    EPSC_OP_WRITE     = 4'h1,
    EPSC_OP_RMW       = 4'h2,
    EPSC_OP_PUSH      = 4'h3,
    EPSC_OP_POP       = 4'h4,
    EPSC_OP_CALL      = 4'h5,
    EPSC_OP_EXC       = 4'h6,
    EPSC_OP_SET_RPAG  = 4'h7,
    EPSC_OP_SET_WPAG  = 4'h8,
    EPSC_OP_SET_STACK_LIMIT_REG = 4'h9,
    EPSC_OP_SET_SP    = 4'ha
  } epsc_op_t;

  // Device sequencer states
  typedef enum logic [3:0] {
    EPSC_ST_IDLE  = 4'h1,
    EPSC_ST_RD    = 4'h2,
    EPSC_ST_XTRA  = 4'h4,
    EPSC_ST_PUSH2 = 4'h8
  } epsc_dst_t;

  // Controller register byte offsets
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_EA     = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_PCHI   = 5'h0c;
  localparam logic [4:0] REG_RDATA  = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_MASK   = 5'h18;
  localparam logic [4:0] REG_SP     = 5'h1c;

  // Field positions
  localparam int unsigned CMD_SPPTR_BIT = 4;
  localparam int unsigned CMD_REP_BIT   = 5;
  localparam int unsigned ST_DONE_BIT   = 0;
  localparam int unsigned ST_ADDR_BIT   = 1;
  localparam int unsigned ST_STK_BIT    = 2;
  localparam int unsigned ST_BUSY_BIT   = 8;
  localparam int unsigned EVT_W         = 3;
  localparam logic [2:0]  MASK_RESET    = 3'h0;

endpackage

// >>> epsc_link.sv
// Link between the core sequencer and the paging and stack check logic
`timescale 1ns/1ns
interface epsc_link;
  // Request from core
  logic                 req;
  epsc_pkg::epsc_op_t   op;
  logic [15:0]          ea;
  logic [15:0]          wdata;
  logic [23:0]          pc;
  logic [7:0]           status_low_byte;
  logic                 sp_ptr;
  logic                 rep;
  // Answer from device
  logic                 ready;
  logic                 done;
  logic [15:0]          rdata;
  logic                 trap_addr;
  logic                 trap_stack;
  logic [15:0]          sp;

  modport dev (
    input  req, op, ea, wdata, pc, status_low_byte, sp_ptr, rep,
    output ready, done, rdata, trap_addr, trap_stack, sp
  );
  modport core (
    output req, op, ea, wdata, pc, status_low_byte, sp_ptr, rep,
    input  ready, done, rdata, trap_addr, trap_stack, sp
  );
endinterface

// >>> epsc_dev.sv
// Extended data window paging and software stack checking
// How it works
// [RULE1] Write: page low 9 bits over EA[14:0]
// [RULE2] Read: read page 9 bits over EA[14:0]
// [RULE3] Extended read costs one extra cycle
// [RULE4] Extended write completes in one cycle
// [RULE5] Software loads write page before setting bit15
// [RULE6] Pages never change on pointer wrap
// [RULE7] No extended read-modify-write inside repeat
// [RULE8] Read-modify-write uses the read page
// [RULE9] Low addresses bypass both page registers
// [RULE10] Page zero with high EA traps
// [RULE11] Stack pointer post-increments push, pre-decrements pop
// [RULE12] Call push clears stacked upper byte
// [RULE13] Exception push stacks status low byte
// [RULE14] Stack limit unreset, bit 0 zero
// [RULE15] Stack pointer addresses compared to limit
// [RULE16] Push at limit passes, next traps
// [RULE17] Stack pointer below 0800h traps
// [RULE18] No stack read right after limit write
// [RULE19] Traps pulse once, faulting access dropped
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module epsc_dev (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Core side
  epsc_link.dev            lnk,
  // Data memory and parallel port side
  output logic             mem_req,
  output logic             mem_we,
  output logic [23:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata
);

  typedef struct packed {
    epsc_pkg::epsc_dst_t state;
    logic [9:0]          rpag;
    logic [8:0]          wpag;
    logic [15:0]         stack_limit_reg;
    logic [15:0]         sp;
    logic                slow;
    logic                rmw;
    logic [15:0]         hold;
    logic                mem_req;
    logic                mem_we;
    logic [23:0]         mem_addr;
    logic [15:0]         mem_wdata;
    logic [15:0]         rdata;
    logic                done;
    logic                trap_a;
    logic                trap_s;
  } epsc_dev_st_t;

  epsc_dev_st_t st_r;
  epsc_dev_st_t st_nxt;

  logic        ext;
  logic [23:0] rd_addr;
  logic [23:0] wr_addr;
  logic        rd_bad;
  logic        wr_bad;
  logic [15:0] sp_dec;

  function automatic logic stk_bad(input logic [15:0] a, input logic [15:0] lim);
    stk_bad = (a > lim) || (a < epsc_pkg::SFR_TOP); // [RULE15] [RULE16] [RULE17]
  endfunction

  assign ext    = lnk.ea[epsc_pkg::EXT_BIT];
  // Low window passes straight through, pages unused
  assign rd_addr = ext ? {st_r.rpag[8:0], lnk.ea[14:0]}            // [RULE2]
                       : {8'h00, lnk.ea};                           // [RULE9]
  assign wr_addr = ext ? {st_r.wpag, lnk.ea[14:0]}                 // [RULE1]
                       : {8'h00, lnk.ea};                           // [RULE9]
  // Program space view is not served here, so it is refused too
  assign rd_bad = ext && ((st_r.rpag == 10'h000) || st_r.rpag[epsc_pkg::PVIEW_BIT]); // [RULE10]
  assign wr_bad = ext && (st_r.wpag == 9'h000);                     // [RULE10]
  assign sp_dec = st_r.sp - epsc_pkg::SP_STEP;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.mem_req   = 1'b0;
    st_nxt.mem_we    = 1'b0;
    st_nxt.done      = 1'b0;
    st_nxt.trap_a    = 1'b0; // [RULE19]
    st_nxt.trap_s    = 1'b0; // [RULE19]
    case (st_r.state)
      epsc_pkg::EPSC_ST_IDLE: begin
        if (lnk.req) begin
          case (lnk.op)
            epsc_pkg::EPSC_OP_READ,
            epsc_pkg::EPSC_OP_RMW: begin
              // Both halves of a read-modify-write go through the read page
              if (rd_bad) begin
                st_nxt.trap_a = 1'b1; // [RULE10] [RULE8]
                st_nxt.done   = 1'b1;
              end else if (lnk.sp_ptr && stk_bad(lnk.ea, st_r.stack_limit_reg)) begin
                st_nxt.trap_s = 1'b1; // [RULE15] [RULE18]
                st_nxt.done   = 1'b1;
              end else begin
                st_nxt.mem_req  = 1'b1;
                st_nxt.mem_addr = rd_addr; // [RULE8]
                st_nxt.slow     = ext;     // [RULE3]
                st_nxt.rmw      = (lnk.op == epsc_pkg::EPSC_OP_RMW);
                st_nxt.hold     = lnk.wdata;
                st_nxt.state    = epsc_pkg::EPSC_ST_RD;
              end
            end
            epsc_pkg::EPSC_OP_WRITE: begin
              if (wr_bad) begin
                st_nxt.trap_a = 1'b1; // [RULE10]
              end else if (lnk.sp_ptr && stk_bad(lnk.ea, st_r.stack_limit_reg)) begin
                st_nxt.trap_s = 1'b1; // [RULE15]
              end else begin
                st_nxt.mem_req   = 1'b1;
                st_nxt.mem_we    = 1'b1;
                st_nxt.mem_addr  = wr_addr;
                st_nxt.mem_wdata = lnk.wdata;
              end
              st_nxt.done = 1'b1; // [RULE4]
            end
            epsc_pkg::EPSC_OP_PUSH,
            epsc_pkg::EPSC_OP_CALL,
            epsc_pkg::EPSC_OP_EXC: begin
              if (stk_bad(st_r.sp, st_r.stack_limit_reg)) begin
                st_nxt.trap_s = 1'b1; // [RULE16] [RULE17]
                st_nxt.done   = 1'b1;
              end else begin
                st_nxt.mem_req   = 1'b1;
                st_nxt.mem_we    = 1'b1;
                st_nxt.mem_addr  = {8'h00, st_r.sp};
                st_nxt.sp        = st_r.sp + epsc_pkg::SP_STEP; // [RULE11]
                if (lnk.op == epsc_pkg::EPSC_OP_PUSH) begin
                  st_nxt.mem_wdata = lnk.wdata;
                  st_nxt.done      = 1'b1;
                end else begin
                  st_nxt.mem_wdata = lnk.pc[15:0];
                  if (lnk.op == epsc_pkg::EPSC_OP_CALL) begin
                    st_nxt.hold = {8'h00, lnk.pc[23:16]}; // [RULE12]
                  end else begin
                    st_nxt.hold = {lnk.status_low_byte, lnk.pc[23:16]}; // [RULE13]
                  end
                  st_nxt.state = epsc_pkg::EPSC_ST_PUSH2;
                end
              end
            end
            epsc_pkg::EPSC_OP_POP: begin
              if (sp_dec < epsc_pkg::SFR_TOP) begin
                st_nxt.trap_s = 1'b1; // [RULE17]
                st_nxt.done   = 1'b1;
              end else begin
                st_nxt.sp       = sp_dec; // [RULE11]
                st_nxt.mem_req  = 1'b1;
                st_nxt.mem_addr = {8'h00, sp_dec};
                st_nxt.slow     = 1'b0;
                st_nxt.rmw      = 1'b0;
                st_nxt.state    = epsc_pkg::EPSC_ST_RD;
              end
            end
            epsc_pkg::EPSC_OP_SET_RPAG: begin
              st_nxt.rpag = lnk.wdata[9:0];
              st_nxt.done = 1'b1;
            end
            epsc_pkg::EPSC_OP_SET_WPAG: begin
              st_nxt.wpag = lnk.wdata[8:0];
              st_nxt.done = 1'b1;
            end
            epsc_pkg::EPSC_OP_SET_STACK_LIMIT_REG: begin
              st_nxt.stack_limit_reg = {lnk.wdata[15:1], 1'b0}; // [RULE14]
              st_nxt.done  = 1'b1;
            end
            epsc_pkg::EPSC_OP_SET_SP: begin
              st_nxt.sp   = {lnk.wdata[15:1], 1'b0};
              st_nxt.done = 1'b1;
            end
            default: begin
              st_nxt.done = 1'b1;
            end
          endcase
        end
      end
      epsc_pkg::EPSC_ST_RD: begin
        st_nxt.rdata = mem_rdata;
        if (st_r.rmw) begin
          // Repeat with an extended target is left to software
          st_nxt.mem_req   = 1'b1; // [RULE7]
          st_nxt.mem_we    = 1'b1;
          st_nxt.mem_wdata = mem_rdata ^ st_r.hold;
        end
        if (st_r.slow) begin
          st_nxt.state = epsc_pkg::EPSC_ST_XTRA; // [RULE3]
        end else begin
          st_nxt.done  = 1'b1;
          st_nxt.state = epsc_pkg::EPSC_ST_IDLE;
        end
      end
      epsc_pkg::EPSC_ST_XTRA: begin
        st_nxt.done  = 1'b1; // [RULE3]
        st_nxt.state = epsc_pkg::EPSC_ST_IDLE;
      end
      epsc_pkg::EPSC_ST_PUSH2: begin
        if (stk_bad(st_r.sp, st_r.stack_limit_reg)) begin
          st_nxt.trap_s = 1'b1; // [RULE16] [RULE17]
        end else begin
          st_nxt.mem_req   = 1'b1;
          st_nxt.mem_we    = 1'b1;
          st_nxt.mem_addr  = {8'h00, st_r.sp};
          st_nxt.mem_wdata = st_r.hold;
          st_nxt.sp        = st_r.sp + epsc_pkg::SP_STEP; // [RULE11]
        end
        st_nxt.done  = 1'b1;
        st_nxt.state = epsc_pkg::EPSC_ST_IDLE;
      end
      default: begin
        st_nxt.state = epsc_pkg::EPSC_ST_IDLE;
      end
    endcase
  end

  // Pages are only loaded by reset or by command, never by pointer arithmetic
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r           <= '0;
      st_r.state     <= epsc_pkg::EPSC_ST_IDLE;
      st_r.rpag      <= epsc_pkg::RPAG_RESET; // [RULE6]
      st_r.wpag      <= epsc_pkg::WPAG_RESET;
      st_r.sp        <= epsc_pkg::SP_RESET;
      st_r.stack_limit_reg     <= st_r.stack_limit_reg; // [RULE14]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.ready      = (st_r.state == epsc_pkg::EPSC_ST_IDLE);
  assign lnk.done       = st_r.done;
  assign lnk.rdata      = st_r.rdata;
  assign lnk.trap_addr  = st_r.trap_a;
  assign lnk.trap_stack = st_r.trap_s;
  assign lnk.sp         = st_r.sp;
  assign mem_req        = st_r.mem_req;
  assign mem_we         = st_r.mem_we;
  assign mem_addr       = st_r.mem_addr;
  assign mem_wdata      = st_r.mem_wdata;

endmodule

// >>> epsc_core.sv
// Core-side command issuer with Avalon-MM register access
`timescale 1ns/1ns
module epsc_core (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Link to device
  epsc_link.core           lnk
);

  typedef struct packed {
    logic               req;
    logic               busy;
    epsc_pkg::epsc_op_t op;
    logic               sp_ptr;
    logic               rep;
    logic [15:0]        ea;
    logic [15:0]        wdata;
    logic [15:0]        pchi;
    logic [15:0]        rdata;
    logic [2:0]         evt;
    logic [2:0]         mask;
    logic               rd_ack;
    logic [31:0]        readdata;
  } epsc_core_st_t;

  epsc_core_st_t st_r;
  epsc_core_st_t st_nxt;

  logic        wr_ok;
  logic        rd_take;
  logic [2:0]  evt_set;

  // A command write stalls while the previous command runs
  assign wr_ok   = avs_write && !(avs_address == epsc_pkg::REG_CMD && st_r.busy);
  assign rd_take = avs_read && st_r.rd_ack;
  assign evt_set = {lnk.trap_stack, lnk.trap_addr, lnk.done};

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rd_ack = avs_read && !st_r.rd_ack;
    if (lnk.req && lnk.ready) begin
      st_nxt.req = 1'b0;
    end
    if (lnk.done) begin
      st_nxt.busy  = 1'b0;
      st_nxt.rdata = lnk.rdata;
    end
    if (wr_ok) begin
      case (avs_address)
        epsc_pkg::REG_CMD: begin
          st_nxt.op     = epsc_pkg::epsc_op_t'(avs_writedata[3:0]);
          st_nxt.sp_ptr = avs_writedata[epsc_pkg::CMD_SPPTR_BIT];
          st_nxt.rep    = avs_writedata[epsc_pkg::CMD_REP_BIT];
          st_nxt.req    = 1'b1;
          st_nxt.busy   = 1'b1;
        end
        epsc_pkg::REG_EA:    st_nxt.ea    = avs_writedata[15:0];
        epsc_pkg::REG_WDATA: st_nxt.wdata = avs_writedata[15:0];
        epsc_pkg::REG_PCHI:  st_nxt.pchi  = avs_writedata[15:0];
        epsc_pkg::REG_MASK:  st_nxt.mask  = avs_writedata[2:0];
        default: begin
        end
      endcase
    end
    case (avs_address)
      epsc_pkg::REG_CMD:    st_nxt.readdata = {26'h0, st_r.rep, st_r.sp_ptr, st_r.op};
      epsc_pkg::REG_EA:     st_nxt.readdata = {16'h0, st_r.ea};
      epsc_pkg::REG_WDATA:  st_nxt.readdata = {16'h0, st_r.wdata};
      epsc_pkg::REG_PCHI:   st_nxt.readdata = {16'h0, st_r.pchi};
      epsc_pkg::REG_RDATA:  st_nxt.readdata = {16'h0, st_r.rdata};
      epsc_pkg::REG_STATUS: st_nxt.readdata = {23'h0, st_r.busy, 5'h0, st_r.evt};
      epsc_pkg::REG_MASK:   st_nxt.readdata = {29'h0, st_r.mask};
      epsc_pkg::REG_SP:     st_nxt.readdata = {16'h0, lnk.sp};
      default:              st_nxt.readdata = 32'h0;
    endcase
    // Read clears only the bits it reported, so no event is lost unseen
    if (rd_take && avs_address == epsc_pkg::REG_STATUS) begin
      st_nxt.evt = (st_r.evt & ~st_r.readdata[2:0]) | evt_set;
    end else begin
      st_nxt.evt = st_r.evt | evt_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r      <= '0;
      st_r.mask <= epsc_pkg::MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_waitrequest     = (avs_read && !st_r.rd_ack) || (avs_write && !wr_ok);
  assign avs_readdata        = st_r.readdata;
  assign irq                 = |(st_r.evt & st_r.mask);
  assign lnk.req             = st_r.req;
  assign lnk.op              = st_r.op;
  assign lnk.ea              = st_r.ea;
  assign lnk.wdata           = st_r.wdata;
  assign lnk.pc              = {st_r.pchi[7:0], st_r.wdata};
  assign lnk.status_low_byte = st_r.pchi[15:8];
  assign lnk.sp_ptr          = st_r.sp_ptr;
  assign lnk.rep             = st_r.rep;

endmodule

// >>> epsc_properties.sv
// Link and memory-side assertions for the paging and stack check block
`timescale 1ns/1ns
module epsc_properties (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               srst,
  // Link
  input wire logic               req,
  input wire epsc_pkg::epsc_op_t op,
  input wire logic [15:0]        ea,
  input wire logic [15:0]        wdata,
  input wire logic [23:0]        pc,
  input wire logic [7:0]         status_low_byte,
  input wire logic               sp_ptr,
  input wire logic               ready,
  input wire logic               done,
  input wire logic               trap_addr,
  input wire logic               trap_stack,
  input wire logic [15:0]        sp,
  // Memory side
  input wire logic               mem_req,
  input wire logic               mem_we,
  input wire logic [23:0]        mem_addr,
  input wire logic [15:0]        mem_wdata
);
  logic        take;
  logic        rd;
  logic        wr;
  logic [9:0]  rpag_h;
  logic [8:0]  wpag_h;
  logic [15:0] lim_h;
  logic [15:0] ea_t;
  logic [15:0] sp_t;
  logic [15:0] wd_t;
  logic [23:0] pc_t;
  logic [7:0]  hi_t;

  assign take = req && ready;
  assign rd   = take && op == epsc_pkg::EPSC_OP_READ && !sp_ptr;
  assign wr   = take && op == epsc_pkg::EPSC_OP_WRITE && !sp_ptr;

  // Shadows of pages and limit; limit left unreset like the real one
  always_ff @(posedge mclk) begin
    if (take) begin
      ea_t <= ea;
      sp_t <= sp;
      wd_t <= wdata;
      pc_t <= pc;
      hi_t <= (op == epsc_pkg::EPSC_OP_EXC) ? status_low_byte : 8'h00;
    end
    if (take && op == epsc_pkg::EPSC_OP_SET_STACK_LIMIT_REG) begin
      lim_h <= {wdata[15:1], 1'b0};
    end
    if (srst) begin
      rpag_h <= epsc_pkg::RPAG_RESET;
      wpag_h <= epsc_pkg::WPAG_RESET;
    end else if (take && op == epsc_pkg::EPSC_OP_SET_RPAG) begin
      rpag_h <= wdata[9:0];
    end else if (take && op == epsc_pkg::EPSC_OP_SET_WPAG) begin
      wpag_h <= wdata[8:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  wr_ext_addr_a : assert property (
    wr && ea[15] && wpag_h != 9'h000 |=> mem_req && mem_we && done
      && mem_addr == {wpag_h, ea_t[14:0]} && mem_wdata == wd_t)
    else $error("extended write address or timing wrong");
  rd_ext_time_a : assert property (
    rd && ea[15] && !rpag_h[9] && rpag_h != 10'h000 |=> mem_req && !mem_we
      && mem_addr == {rpag_h[8:0], ea_t[14:0]} ##1 !done ##1 done)
    else $error("extended read address or timing wrong");
  rmw_read_page_a : assert property (
    take && op == epsc_pkg::EPSC_OP_RMW && ea[15] && !rpag_h[9] && rpag_h != 10'h000
      |=> mem_req && !mem_we && mem_addr == {rpag_h[8:0], ea_t[14:0]})
    else $error("read-modify-write not paged by read page");
  near_bypass_a : assert property (
    (rd || wr) && !ea[15] |=> mem_req && mem_addr == {8'h00, ea_t})
    else $error("low address not mapped directly");
  page_zero_a : assert property (
    (rd && ea[15] && rpag_h == 10'h000) || (wr && ea[15] && wpag_h == 9'h000)
      |=> trap_addr && done && !mem_req ##1 !trap_addr)
    else $error("page zero access not trapped once");
  push_ok_a : assert property (
    take && op == epsc_pkg::EPSC_OP_PUSH && sp >= epsc_pkg::SFR_TOP && sp <= lim_h
      |=> done && mem_we && !trap_stack && mem_addr == {8'h00, sp_t}
      && sp == sp_t + 16'h0002)
    else $error("push within limit wrong");
  push_over_a : assert property (
    take && op == epsc_pkg::EPSC_OP_PUSH && sp > lim_h
      |=> trap_stack && !mem_req && sp == sp_t)
    else $error("push beyond limit not trapped");
  pop_floor_a : assert property (
    take && op == epsc_pkg::EPSC_OP_POP && sp < 16'h0802
      |=> trap_stack && !mem_req ##1 !trap_stack)
    else $error("pop below floor not trapped once");
  pop_step_a : assert property (
    take && op == epsc_pkg::EPSC_OP_POP && sp >= 16'h0802 |=> mem_req && !mem_we
      && mem_addr == {8'h00, sp_t - 16'h0002} ##1 done && sp == sp_t - 16'h0002)
    else $error("pop not pre-decremented");
  call_frame_a : assert property (
    take && (op == epsc_pkg::EPSC_OP_CALL || op == epsc_pkg::EPSC_OP_EXC)
      && sp >= epsc_pkg::SFR_TOP && sp < lim_h
      |=> mem_we && mem_addr == {8'h00, sp_t} && mem_wdata == wd_t
      ##1 mem_we && done && mem_wdata == {hi_t, pc_t[23:16]})
    else $error("call frame upper word wrong");
  sp_ptr_bound_a : assert property (
    take && sp_ptr && op == epsc_pkg::EPSC_OP_READ
      && (ea > lim_h || ea < epsc_pkg::SFR_TOP) |=> trap_stack && !mem_req)
    else $error("stack pointer access out of bounds not trapped");
endmodule

// >>> test_eds_paging_and_stack_check.sv
// Self-checking bench: core issuer and paging device joined over the link
`timescale 1ns/1ns
module test_eds_paging_and_stack_check;
  logic        mclk;
  logic        srst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        mem_req;
  logic        mem_we;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [40:0] acc_q[$];
  logic [31:0] rd_v;
  logic [2:0]  st;
  int          n_errors;
  int          num_checks;

  epsc_link lnk ();
  epsc_core epsc_core_inst (.mclk(mclk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .lnk(lnk));
  epsc_dev epsc_dev_inst (.mclk(mclk), .srst(srst), .lnk(lnk), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  epsc_properties epsc_properties_inst (.mclk(mclk), .srst(srst), .req(lnk.req), .op(lnk.op),
    .ea(lnk.ea), .wdata(lnk.wdata), .pc(lnk.pc), .status_low_byte(lnk.status_low_byte),
    .sp_ptr(lnk.sp_ptr), .ready(lnk.ready), .done(lnk.done), .trap_addr(lnk.trap_addr),
    .trap_stack(lnk.trap_stack), .sp(lnk.sp), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata));

  // Memory content is a fixed function of address, so reads are predictable
  function automatic logic [15:0] mpat(input logic [23:0] a);
    return a[15:0] ^ {a[23:16], 8'h3c};
  endfunction
  assign mem_rdata = mpat(mem_addr);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (mem_req === 1'b1) begin
      acc_q.push_back({mem_we, mem_addr, mem_wdata});
    end
  end

  task automatic chk(input string nm, input logic [40:0] exp, input logic [40:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic rw, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !rw;
    avs_write <= rw;
    @(posedge mclk iff avs_waitrequest === 1'b0);
    rd_v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // Launch one command and gather status until done shows up
  task automatic cmd(input epsc_pkg::epsc_op_t op, input logic [15:0] ea,
                     input logic [15:0] wd, input logic [15:0] pchi, input logic spp);
    int n;
    n = 0;
    st = 3'h0;
    bus(1'b1, epsc_pkg::REG_EA, {16'h0, ea});
    bus(1'b1, epsc_pkg::REG_WDATA, {16'h0, wd});
    bus(1'b1, epsc_pkg::REG_PCHI, {16'h0, pchi});
    acc_q.delete();
    bus(1'b1, epsc_pkg::REG_CMD, {26'h0, 1'b0, spp, op});
    while (st[0] !== 1'b1 && n < 20) begin
      bus(1'b0, epsc_pkg::REG_STATUS, 32'h0);
      st = st | rd_v[2:0];
      n++;
    end
  endtask

  task automatic rd_chk(input logic [15:0] ea, input logic [23:0] xa);
    cmd(epsc_pkg::EPSC_OP_READ, ea, 16'h0, 16'h0, 1'b0);
    chk("rd_addr", 41'({1'b0, xa}), 41'(acc_q[0][40:16]));
    bus(1'b0, epsc_pkg::REG_RDATA, 32'h0);
    chk("rd_data", 41'(mpat(xa)), 41'(rd_v[15:0]));
  endtask

  task automatic t_reset;
    bus(1'b0, epsc_pkg::REG_SP, 32'h0);
    chk("sp_reset", 41'(epsc_pkg::SP_RESET), 41'(rd_v));
    bus(1'b0, epsc_pkg::REG_MASK, 32'h0);
    chk("mask_reset", 41'h0, 41'(rd_v));
    bus(1'b0, 5'h1e, 32'h0);
    chk("unmapped", 41'h0, 41'(rd_v));
    $display("t_reset finished");
  endtask

  task automatic t_paging;
    cmd(epsc_pkg::EPSC_OP_SET_RPAG, 16'h0, 16'h0002, 16'h0, 1'b0);
    cmd(epsc_pkg::EPSC_OP_SET_WPAG, 16'h0, 16'h0003, 16'h0, 1'b0);
    cmd(epsc_pkg::EPSC_OP_WRITE, 16'h8004, 16'h1234, 16'h0, 1'b0);
    chk("ext_wr", {1'b1, 24'h018004, 16'h1234}, acc_q[0]);
    rd_chk(16'h8800, 24'h010800);
    rd_chk(16'hfffe, 24'h017ffe);
    rd_chk(16'h8000, 24'h010000);
    rd_chk(16'h1000, 24'h001000);
    // Outside any repeat loop
    cmd(epsc_pkg::EPSC_OP_RMW, 16'h8010, 16'h00ff, 16'h0, 1'b0);
    chk("rmw_wb", {1'b1, 24'h010010, mpat(24'h010010) ^ 16'h00ff}, acc_q[1]);
    $display("t_paging finished");
  endtask

  task automatic t_page0;
    cmd(epsc_pkg::EPSC_OP_SET_RPAG, 16'h0, 16'h0000, 16'h0, 1'b0);
    cmd(epsc_pkg::EPSC_OP_SET_WPAG, 16'h0, 16'h0000, 16'h0, 1'b0);
    cmd(epsc_pkg::EPSC_OP_WRITE, 16'h8000, 16'h5555, 16'h0, 1'b0);
    chk("wr_p0_st", 41'h3, 41'(st));
    chk("wr_p0_n", 41'h0, 41'(acc_q.size()));
    cmd(epsc_pkg::EPSC_OP_READ, 16'h9000, 16'h0, 16'h0, 1'b0);
    chk("rd_p0_st", 41'h3, 41'(st));
    chk("rd_p0_n", 41'h0, 41'(acc_q.size()));
    rd_chk(16'h0900, 24'h000900);
    $display("t_page0 finished");
  endtask

  task automatic t_irq;
    bus(1'b1, epsc_pkg::REG_EA, 32'h9000);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, epsc_pkg::REG_MASK, (j == 0) ? 32'h2 : 32'h4);
      bus(1'b1, epsc_pkg::REG_CMD, {28'h0, epsc_pkg::EPSC_OP_READ});
      repeat (8) @(posedge mclk);
      chk("irq_set", 41'(j == 0), 41'(irq));
      bus(1'b0, epsc_pkg::REG_STATUS, 32'h0);
      chk("irq_status", 41'h3, 41'(rd_v[2:0]));
      chk("irq_clear", 41'h0, 41'(irq));
    end
    $display("t_irq finished");
  endtask

  task automatic t_stack;
    // Limit loaded before any stack use; odd value must lose bit 0
    cmd(epsc_pkg::EPSC_OP_SET_STACK_LIMIT_REG, 16'h0, 16'h0805, 16'h0, 1'b0);
    cmd(epsc_pkg::EPSC_OP_SET_SP, 16'h0, 16'h0800, 16'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd(epsc_pkg::EPSC_OP_PUSH, 16'h0, 16'h1000 + 16'(i), 16'h0, 1'b0);
      chk("push_st", (i == 3) ? 41'h5 : 41'h1, 41'(st));
      if (i < 3) begin
        chk("push", {1'b1, 24'h000800 + 24'(2 * i), 16'h1000 + 16'(i)}, acc_q[0]);
      end
    end
    for (int i = 0; i < 4; i++) begin
      cmd(epsc_pkg::EPSC_OP_POP, 16'h0, 16'h0, 16'h0, 1'b0);
      chk("pop_st", (i == 3) ? 41'h5 : 41'h1, 41'(st));
      if (i < 3) begin
        chk("pop", 41'({1'b0, 24'h000804 - 24'(2 * i)}), 41'(acc_q[0][40:16]));
      end
    end
    bus(1'b0, epsc_pkg::REG_SP, 32'h0);
    chk("sp_after", 41'h0800, 41'(rd_v));
    cmd(epsc_pkg::EPSC_OP_READ, 16'h0700, 16'h0, 16'h0, 1'b1);
    chk("sp_floor", 41'h5, 41'(st));
    cmd(epsc_pkg::EPSC_OP_READ, 16'h0805, 16'h0, 16'h0, 1'b1);
    chk("sp_limit", 41'h5, 41'(st));
    $display("t_stack finished");
  endtask

  task automatic t_call;
    cmd(epsc_pkg::EPSC_OP_SET_STACK_LIMIT_REG, 16'h0, 16'h0ffe, 16'h0, 1'b0);
    cmd(epsc_pkg::EPSC_OP_SET_SP, 16'h0, 16'h0900, 16'h0, 1'b0);
    for (int j = 0; j < 2; j++) begin
      cmd((j == 0) ? epsc_pkg::EPSC_OP_CALL : epsc_pkg::EPSC_OP_EXC, 16'h0, 16'h1234,
          16'h5cab, 1'b0);
      chk("frame_lo", {1'b1, 24'h000900 + 24'(4 * j), 16'h1234}, acc_q[0]);
      chk("frame_hi", {1'b1, 24'h000902 + 24'(4 * j), (j == 0) ? 16'h00ab : 16'h5cab},
          acc_q[1]);
    end
    $display("t_call finished");
  endtask

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    end_sim;
  end

  initial begin
    srst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_paging;
    t_page0;
    t_irq;
    t_stack;
    t_call;
    end_sim;
  end
endmodule
